/* shared/rmsm_pkg.sv */
package rmsm_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ           = 25000000;
   localparam int CLK_NS           = 40;
   localparam int SETTLE_US        = 130;
   localparam int SETTLE_CYC       = (SETTLE_US * 1000) / CLK_NS;
   localparam int PDET_FILT_US     = 40;
   localparam int PDET_FILT_CYC    = (PDET_FILT_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int CE_MIN_US        = 10;
   localparam int CE_MIN_CYC       = (CE_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int OSC_US           = 1500;
   localparam int OSC_CYC          = (OSC_US * 1000) / CLK_NS;
   localparam int TX_MAX_US        = 4000;
   localparam int TX_MAX_CYC       = (TX_MAX_US * 1000) / CLK_NS;
   localparam int LS_REF_MH        = 30;
   localparam int CNT_W            = 20;
   // ----------------------------------------
   // Buffer shape
   // ----------------------------------------
   localparam int FIFO_W           = 8;
   localparam int FIFO_D           = 8;
   // ----------------------------------------
   // Modes
   // ----------------------------------------
   // Nine modes need four bits
   typedef enum logic [3:0] {
      RMSM_POR, RMSM_PDN, RMSM_OSC, RMSM_SBY1, RMSM_SBY2, RMSM_RXS, RMSM_RX,
      RMSM_TXS, RMSM_TX
   } rmsm_mode_e;
endpackage

/* rtl/rmsm_fifo.sv */
`timescale 1ns/10ps
module rmsm_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0]  wp_reg;
   logic [AW:0]  rp_reg;
   logic         push;
   logic         pop;

   assign in_ready  = (wp_reg - rp_reg) != (AW+1)'(D);
   assign out_valid = wp_reg != rp_reg;
   assign out_data  = mem[rp_reg[AW-1:0]];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_reg[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_reg <= '0;
         rp_reg <= '0;
      end else begin
         if (push) begin
            wp_reg <= wp_reg + 1'b1;
         end
         if (pop) begin
            rp_reg <= rp_reg + 1'b1;
         end
      end
   end
endmodule

/* rtl/rmsm_top.sv */
`timescale 1ns/10ps
// What this block does
// [RL1] After reset, leave the reset state only into power down.
// [RL2] Power down keeps settings and the host port usable.
// [RL3] Power-up bit low forces power down, overriding role and activate.
// [RL4] Power-up bit set in power down leads to standby-I.
// [RL5] Active modes need activate high; activate low returns to standby-I.
// [RL6] Transmitter role, activate high, empty transmit FIFO: standby-II.
// [RL7] New packet in standby-II starts synthesizer, transmits after 130 us.
// [RL8] Standby-II launches when chip select returns high after upload.
// [RL9] Power-up, receive role and activate high give receive mode.
// [RL10] Receive accepts only address-matching CRC-good packets into a free slot.
// [RL11] Valid packet with receive FIFO full is dropped.
// [RL12] Receive holds until host changes mode, unless protocol engine acts.
// [RL13] Power flag rises only after 40 us of strong in-channel signal.
// [RL14] Transmit entry: power-up, transmit role, payload, activate over 10 us.
// [RL15] Finish current packet; activate low then returns to standby-I.
// [RL16] After packet with activate high: next packet or standby-II.
// [RL17] Host keeps each transmit stretch under 4 ms.
// [RL18] With protocol engine on, transmit never exceeds 4 ms.
// [RL19] Activate held high drains and keeps draining a refilled FIFO.
// [RL20] Short activate pulse sends one packet then standby-I.
// [RL21] Power down to standby bounded by 1.5 ms, scaled by inductance.
// [RL22] Host waits oscillator startup before raising activate.
// [RL23] Standby to active, or between active modes, within 130 us.
// [RL24] Power-up bit resets cleared so device rests in power down.
module rmsm_top
   import rmsm_pkg::*;
#(
   parameter int W        = FIFO_W,
   parameter int D        = FIFO_D,
   parameter int LS_MH    = LS_REF_MH,
   parameter int OSC_CNT  = (OSC_CYC * LS_MH) / LS_REF_MH,
   parameter int TXMAX    = TX_MAX_CYC,
   parameter int SETTLE   = SETTLE_CYC
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         power_on_request_bit,
   input  wire logic         receive_role_select,
   input  wire logic         chip_activate,
   input  wire logic         auto_protocol_en,
   input  wire logic         spi_csn,
   input  wire logic [W-1:0] tx_wdata,
   input  wire logic         tx_wvalid,
   output logic              tx_wready,
   input  wire logic         tx_done,
   input  wire logic         rx_pkt_valid,
   input  wire logic         rx_addr_match,
   input  wire logic         rx_crc_ok,
   input  wire logic [W-1:0] rx_payload,
   input  wire logic         rx_rdready,
   output logic [W-1:0]      rx_rdata,
   output logic              rx_rdvalid,
   input  wire logic         rf_power_high,
   output logic [3:0]        mode,
   output logic              received_power_flag,
   output logic              synth_on,
   output logic              tx_start,
   output logic              rx_drop
);
   localparam int QCW = $clog2(D) + 1;
   rmsm_mode_e       st_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] txt_reg;
   logic [CNT_W-1:0] pdet_reg;
   logic [QCW-1:0]   txq_cnt_reg;
   logic             tx_end;
   logic             txq_more;
   logic             prim_tx_role;
   logic             txq_valid;
   logic             txq_pop;
   logic             rxq_ready;
   logic             rx_accept;
   logic             rx_push;
   logic [W-1:0]     txq_data;
   logic [W-1:0]     rx_rdata_w;
   logic             rx_rdvalid_w;
   logic             tx_wready_w;

   assign prim_tx_role = !receive_role_select;

   // ----------------------------------------
   // Buffers
   // ----------------------------------------
   // [RL2] Transmit queue takes uploads in every mode, power down too
   // Transmit queue; upload is stalled by the buffer's own ready
   rmsm_fifo #(.W(W), .D(D)) u_txq (
      .clk       (clk),
      .rst       (rst),
      .in_data   (tx_wdata),
      .in_valid  (tx_wvalid),
      .in_ready  (tx_wready_w),
      .out_data  (txq_data),
      .out_valid (txq_valid),
      .out_ready (txq_pop)
   );

   // [RL10] Address and CRC filter
   assign rx_accept = rx_pkt_valid && rx_addr_match && rx_crc_ok && st_reg == RMSM_RX;
   assign rx_push   = rx_accept && rxq_ready;

   rmsm_fifo #(.W(W), .D(D)) u_rxq (
      .clk       (clk),
      .rst       (rst),
      .in_data   (rx_payload),
      .in_valid  (rx_push),
      .in_ready  (rxq_ready),
      .out_data  (rx_rdata_w),
      .out_valid (rx_rdvalid_w),
      .out_ready (rx_rdready)
   );

   assign rx_rdata   = rx_rdata_w;
   assign rx_rdvalid = rx_rdvalid_w;
   assign tx_wready  = tx_wready_w;
   // Packet leaves the queue at its end; a capped stretch gives the packet up
   assign tx_end     = (st_reg == RMSM_TX)
                       && (tx_done || (auto_protocol_en && txt_reg >= CNT_W'(TXMAX - 1)));
   assign txq_pop    = tx_end;
   // Queue valid alone cannot tell the last packet from one with a successor
   assign txq_more   = txq_cnt_reg > QCW'(1);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txq_cnt_reg <= '0;
      end else begin
         txq_cnt_reg <= txq_cnt_reg + QCW'(tx_wvalid && tx_wready_w) - QCW'(txq_pop);
      end
   end

   // ----------------------------------------
   // Mode machine
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg  <= RMSM_POR;
         cnt_reg <= '0;
      end else if (!power_on_request_bit && st_reg != RMSM_POR) begin
         // [RL3] Power-up low wins
         st_reg  <= RMSM_PDN;
         cnt_reg <= '0;
      end else begin
         unique case (st_reg)
            // [RL1] [RL24] Reset leads only to power down
            RMSM_POR: begin
               st_reg <= RMSM_PDN;
            end
            // [RL4] Power-up into standby via oscillator start
            RMSM_PDN: begin
               if (power_on_request_bit) begin
                  st_reg  <= RMSM_OSC;
                  cnt_reg <= '0;
               end
            end
            // [RL21] Bounded oscillator startup
            RMSM_OSC: begin
               if (cnt_reg >= CNT_W'(OSC_CNT - 1)) begin
                  st_reg <= RMSM_SBY1;
               end else begin
                  cnt_reg <= cnt_reg + 1'b1;
               end
            end
            // [RL5] [RL9] Receive entry; [RL14] transmit entry needs payload
            RMSM_SBY1: begin
               cnt_reg <= '0;
               if (chip_activate && receive_role_select) begin
                  st_reg <= RMSM_RXS;
               end else if (chip_activate && txq_valid) begin
                  st_reg <= RMSM_TXS;
               end else if (chip_activate && prim_tx_role) begin
                  st_reg <= RMSM_SBY2;
               end
            end
            // [RL7] [RL8] Launch on new packet once chip select is high
            RMSM_SBY2: begin
               cnt_reg <= '0;
               if (!chip_activate) begin
                  st_reg <= RMSM_SBY1;
               end else if (txq_valid && spi_csn) begin
                  st_reg <= RMSM_TXS;
               end
            end
            // [RL23] Settling bounded by 130 us
            RMSM_RXS, RMSM_TXS: begin
               if (!chip_activate && st_reg == RMSM_RXS) begin
                  st_reg <= RMSM_SBY1;
               end else if (cnt_reg >= CNT_W'(SETTLE - 1)) begin
                  st_reg  <= (st_reg == RMSM_RXS) ? RMSM_RX : RMSM_TX;
                  cnt_reg <= '0;
               end else begin
                  cnt_reg <= cnt_reg + 1'b1;
               end
            end
            // [RL12] Stay in receive until host changes mode
            RMSM_RX: begin
               if (!chip_activate) begin
                  st_reg <= RMSM_SBY1;
               end else if (!receive_role_select) begin
                  st_reg  <= RMSM_TXS;
                  cnt_reg <= '0;
               end
            end
            // [RL15] [RL16] [RL19] [RL20] End of packet decision
            RMSM_TX: begin
               if (tx_end) begin
                  if (!chip_activate) begin
                     st_reg <= RMSM_SBY1;
                  end else if (receive_role_select) begin
                     st_reg  <= RMSM_RXS;
                     cnt_reg <= '0;
                  end else if (txq_more) begin
                     st_reg <= RMSM_TX;
                  end else begin
                     // [RL6] Empty queue, activate high
                     st_reg <= RMSM_SBY2;
                  end
               end
            end
            default: st_reg <= RMSM_POR;
         endcase
      end
   end

   // ----------------------------------------
   // Transmit stretch timer
   // ----------------------------------------
   // [RL18] Protocol engine caps time in transmit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         txt_reg <= '0;
      end else if (st_reg == RMSM_TX && !tx_end) begin
         txt_reg <= txt_reg + 1'b1;
      end else begin
         txt_reg <= '0;
      end
   end

   // ----------------------------------------
   // Power detector filter
   // ----------------------------------------
   // [RL13] Filter: raw detector must persist 40 us
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pdet_reg            <= '0;
         received_power_flag <= 1'b0;
      end else if (st_reg == RMSM_RX && rf_power_high) begin
         if (pdet_reg >= CNT_W'(PDET_FILT_CYC - 1)) begin
            received_power_flag <= 1'b1;
         end else begin
            pdet_reg <= pdet_reg + 1'b1;
         end
      end else if (st_reg == RMSM_RX) begin
         pdet_reg            <= '0;
         received_power_flag <= 1'b0;
      end else begin
         pdet_reg <= '0;
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode        <= 4'h0;
         synth_on    <= 1'b0;
         tx_start    <= 1'b0;
         rx_drop     <= 1'b0;
      end else begin
         mode        <= st_reg;
         synth_on    <= st_reg inside {RMSM_RXS, RMSM_RX, RMSM_TXS, RMSM_TX};
         // [RL7] Launch marker on the last settling cycle of transmit settling
         tx_start    <= (st_reg == RMSM_TXS) && (cnt_reg == CNT_W'(SETTLE - 1));
         // [RL11] Drop when receive queue full
         rx_drop     <= rx_accept && !rxq_ready;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_pdn;
      @(posedge clk) disable iff (rst)
      !power_on_request_bit && st_reg != RMSM_POR |=> st_reg == RMSM_PDN;
   endproperty
   a_pdn: assert property (p_pdn) else $error("power-up low not power down"); // [RL3]

   property p_por;
      @(posedge clk) disable iff (rst)
      st_reg == RMSM_POR |=> st_reg == RMSM_PDN;
   endproperty
   a_por: assert property (p_por) else $error("reset exit not power down"); // [RL1]

   property p_up;
      @(posedge clk) disable iff (rst)
      st_reg == RMSM_PDN && power_on_request_bit |=> st_reg == RMSM_OSC;
   endproperty
   a_up: assert property (p_up) else $error("power-up not started"); // [RL4]

   property p_ce_low;
      @(posedge clk) disable iff (rst)
      st_reg == RMSM_RX && !chip_activate && power_on_request_bit |=> st_reg == RMSM_SBY1;
   endproperty
   a_ce_low: assert property (p_ce_low) else $error("activate low kept receive"); // [RL5]

   sequence s_settle;
      st_reg == RMSM_TXS && $past(st_reg) != RMSM_TXS;
   endsequence
   property p_settle;
      @(posedge clk) disable iff (rst)
      s_settle ##1 (st_reg == RMSM_TXS && power_on_request_bit) [*3] |-> cnt_reg == CNT_W'(3);
   endproperty
   a_settle: assert property (p_settle) else $error("settle count wrong"); // [RL23]

   property p_drop;
      @(posedge clk) disable iff (rst)
      rx_accept && !rxq_ready |=> rx_drop;
   endproperty
   a_drop: assert property (p_drop) else $error("full drop not flagged"); // [RL11]

   property p_pflag;
      @(posedge clk) disable iff (rst)
      $rose(received_power_flag) |-> pdet_reg == CNT_W'(PDET_FILT_CYC - 1);
   endproperty
   a_pflag: assert property (p_pflag) else $error("power flag early"); // [RL13]

   property p_sby2;
      @(posedge clk) disable iff (rst)
      st_reg == RMSM_TX && tx_done && chip_activate && power_on_request_bit
         && prim_tx_role && txq_cnt_reg == QCW'(1) |=> st_reg == RMSM_SBY2;
   endproperty
   a_sby2: assert property (p_sby2) else $error("empty queue not standby-II"); // [RL6]

   property p_txmax;
      @(posedge clk) disable iff (rst)
      auto_protocol_en |-> txt_reg < CNT_W'(TXMAX);
   endproperty
   a_txmax: assert property (p_txmax) else $error("transmit too long"); // [RL18]
endmodule

/* tb/rmsm_host_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Host side: mode bits, activate pin, uploads
// ----------------------------------------
module rmsm_host_model
   import rmsm_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              tx_wready,
   output logic                   power_on_request_bit,
   output logic                   receive_role_select,
   output logic                   chip_activate,
   output logic                   auto_protocol_en,
   output logic                   spi_csn,
   output logic [FIFO_W-1:0]      tx_wdata,
   output logic                   tx_wvalid
);
   initial begin
      power_on_request_bit = 1'b0;
      receive_role_select = 1'b0;
      chip_activate = 1'b0;
      auto_protocol_en = 1'b0;
      spi_csn = 1'b1;
      tx_wdata = 8'hA5;
      tx_wvalid = 1'b0;
   end
   // mode bits
   // Caller waits for standby before raising activate, and keeps transmit stretches short
   task automatic set_mode(input logic p, input logic r, input logic c, input logic a);
      @(negedge clk);
      power_on_request_bit = p;
      receive_role_select = r;
      chip_activate = c;
      auto_protocol_en = a;
   endtask
   // upload framed by chip select
   // Data lines show the inverse once released, so a stale word cannot pass for fresh
   task automatic push(input logic [FIFO_W-1:0] d, output logic ok);
      int n;
      @(negedge clk);
      spi_csn = 1'b0;
      tx_wdata = d;
      tx_wvalid = 1'b1;
      n = 0;
      @(posedge clk);
      while (tx_wready !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      ok = tx_wready;
      @(negedge clk);
      tx_wvalid = 1'b0;
      tx_wdata = ~d;
      spi_csn = 1'b1;
   endtask
endmodule

/* tb/tb_rmsm_top.sv */
`timescale 1ns/10ps
module tb_rmsm_top;
   import rmsm_pkg::*;
   logic              clk;
   logic              rst;
   logic              pwr;
   logic              role;
   logic              ce;
   logic              auto_en;
   logic              csn;
   logic [FIFO_W-1:0] wdata;
   logic              wvalid;
   logic              wready;
   logic              tx_done;
   logic              pkt_v;
   logic              addr_ok;
   logic              crc_ok;
   logic [FIFO_W-1:0] payload;
   logic              rdready;
   logic [FIFO_W-1:0] rdata;
   logic              rdvalid;
   logic              rf_hi;
   logic [3:0]        mode;
   logic              pflag;
   logic              synth;
   logic              tx_start;
   logic              drop;
   logic              ok;
   logic              seen;
   int                bad_count;
   int                comparisons;

   rmsm_top #(.OSC_CNT(20), .TXMAX(50), .SETTLE(4)) uut (
      .clk(clk), .rst(rst), .power_on_request_bit(pwr), .receive_role_select(role),
      .chip_activate(ce), .auto_protocol_en(auto_en), .spi_csn(csn), .tx_wdata(wdata),
      .tx_wvalid(wvalid), .tx_wready(wready), .tx_done(tx_done), .rx_pkt_valid(pkt_v),
      .rx_addr_match(addr_ok), .rx_crc_ok(crc_ok), .rx_payload(payload),
      .rx_rdready(rdready), .rx_rdata(rdata), .rx_rdvalid(rdvalid), .rf_power_high(rf_hi),
      .mode(mode), .received_power_flag(pflag), .synth_on(synth), .tx_start(tx_start),
      .rx_drop(drop)
   );
   rmsm_host_model host (
      .clk(clk), .tx_wready(wready), .power_on_request_bit(pwr),
      .receive_role_select(role), .chip_activate(ce), .auto_protocol_en(auto_en),
      .spi_csn(csn), .tx_wdata(wdata), .tx_wvalid(wvalid)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // ----------------------------------------
   // Checks and waits
   // ----------------------------------------
   task automatic end_sim;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Bounded waits; an exhausted bound ends the run
   task automatic wait_mode(input logic [2:0] m, input int lim);
      int n;
      n = 0;
      while (mode !== {1'b0, m} && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk({4'h0, mode}, {5'h00, m});
      if (mode !== {1'b0, m}) end_sim();
   endtask
   task automatic wait_start(input int lim);
      int n;
      n = 0;
      while (tx_start !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
      chk({7'h00, tx_start}, 8'h01);
      if (tx_start !== 1'b1) end_sim();
   endtask
   task automatic done_pulse;
      @(negedge clk);
      tx_done = 1'b1;
      @(negedge clk);
      tx_done = 1'b0;
   endtask
   // One packet from the radio; drop is looked for over the next few cycles
   task automatic rx_pkt(input logic [7:0] d, input logic a, input logic c);
      @(negedge clk);
      pkt_v = 1'b1;
      addr_ok = a;
      crc_ok = c;
      payload = d;
      @(negedge clk);
      pkt_v = 1'b0;
      payload = ~d;
      seen = drop;
      repeat (2) begin
         @(negedge clk);
         seen = seen | drop;
      end
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      bad_count = 0;
      comparisons = 0;
      rst = 1'b1;
      tx_done = 1'b0;
      pkt_v = 1'b0;
      addr_ok = 1'b0;
      crc_ok = 1'b0;
      payload = 8'h00;
      rdready = 1'b0;
      rf_hi = 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      repeat (3) @(negedge clk);
      chk({4'h0, mode}, {4'h0, 4'(RMSM_PDN)});
      host.push(8'h3C, ok);
      chk({7'h00, ok}, 8'h01);
      host.set_mode(1'b1, 1'b0, 1'b0, 1'b0);
      repeat (4) @(negedge clk);
      chk({4'h0, mode}, {4'h0, 4'(RMSM_OSC)});
      wait_mode(3'(RMSM_SBY1), 40);
      host.set_mode(1'b1, 1'b1, 1'b1, 1'b0);
      wait_mode(3'(RMSM_RX), 12);
      rf_hi = 1'b1;
      repeat (900) @(negedge clk);
      chk({7'h00, pflag}, 8'h00);
      repeat (150) @(negedge clk);
      chk({7'h00, pflag}, 8'h01);
      rx_pkt(8'h11, 1'b1, 1'b0);
      rx_pkt(8'h12, 1'b0, 1'b1);
      chk({7'h00, rdvalid}, 8'h00);
      for (int i = 0; i < FIFO_D; i++) begin
         rx_pkt(8'hA0 + 8'(i), 1'b1, 1'b1);
         chk({7'h00, seen}, 8'h00);
      end
      rx_pkt(8'hFF, 1'b1, 1'b1);
      chk({7'h00, seen}, 8'h01);
      chk({4'h0, mode}, {4'h0, 4'(RMSM_RX)});
      for (int i = 0; i < FIFO_D; i++) begin
         chk({7'h00, rdvalid}, 8'h01);
         chk(rdata, 8'hA0 + 8'(i));
         rdready = 1'b1;
         @(negedge clk);
         rdready = 1'b0;
      end
      chk({7'h00, rdvalid}, 8'h00);
      host.set_mode(1'b1, 1'b1, 1'b0, 1'b0);
      wait_mode(3'(RMSM_SBY1), 5);
      host.set_mode(1'b1, 1'b0, 1'b1, 1'b0);
      wait_start(20);
      repeat (CE_MIN_CYC) @(negedge clk);
      host.set_mode(1'b1, 1'b0, 1'b0, 1'b0);
      done_pulse();
      wait_mode(3'(RMSM_SBY1), 5);
      host.set_mode(1'b1, 1'b0, 1'b1, 1'b0);
      wait_mode(3'(RMSM_SBY2), 10);
      host.push(8'h11, ok);
      host.push(8'h22, ok);
      wait_start(20);
      done_pulse();
      // Second word waits in the queue, so transmit carries straight on
      repeat (2) @(negedge clk);
      chk({4'h0, mode}, {4'h0, 4'(RMSM_TX)});
      done_pulse();
      wait_mode(3'(RMSM_SBY2), 10);
      host.set_mode(1'b1, 1'b0, 1'b1, 1'b1);
      host.push(8'h33, ok);
      wait_start(20);
      wait_mode(3'(RMSM_SBY2), 80);
      host.push(8'h44, ok);
      wait_start(20);
      host.set_mode(1'b0, 1'b0, 1'b1, 1'b0);
      wait_mode(3'(RMSM_PDN), 5);
      end_sim();
   end
endmodule
